// >>> core/gse_encap_pkg.sv
// Shared constants, types and helpers for the packet header encapsulator
package gse_encap_pkg;

  // Label kind codes carried in the packet header
  localparam logic [1:0] LABEL_KIND_SIX = 2'h0;
  localparam logic [1:0] LABEL_KIND_THREE = 2'h1;
  localparam logic [1:0] LABEL_KIND_NONE = 2'h2;
  localparam logic [1:0] LABEL_KIND_REUSE = 2'h3;

  // Short-label binding codes
  localparam logic [2:0] BIND_NONE = 3'h0;
  localparam logic [2:0] BIND_GROUP_LOGON = 3'h4;
  localparam logic [2:0] BIND_ATM_PVC = 3'h2;
  localparam logic [2:0] BIND_VLAN = 3'h1;
  localparam int BIND_RESERVED_BITS = 12;

  // Special label values and multicast prefixes
  localparam logic [47:0] LABEL_BROADCAST = 48'hffff_ffff_ffff;
  localparam logic [47:0] LABEL_ZERO = 48'h0000_0000_0000;
  localparam logic [23:0] MCAST4_PREFIX = 24'h01005e;
  localparam logic [15:0] MCAST6_PREFIX = 16'h3333;
  localparam int MCAST_BIT = 40;

  // Byte counts of the header fields after the length field
  localparam logic [11:0] FRAG_TAG_BYTES = 12'h001;
  localparam logic [11:0] TOTAL_LEN_BYTES = 12'h002;
  localparam logic [11:0] PROTO_BYTES = 12'h002;
  localparam logic [11:0] LABEL_SIX_BYTES = 12'h006;
  localparam logic [11:0] LABEL_THREE_BYTES = 12'h003;
  localparam int HDR_MAX_BYTES = 16;

  // Kind of destination the user asks for
  typedef enum logic [1:0] {
    DEST_UNICAST,
    DEST_BROADCAST,
    DEST_MCAST_V4,
    DEST_MCAST_V6
  } dest_kind_e;

  // One packet order from the user side
  typedef struct packed {
    logic first_frag;
    logic last_frag;
    dest_kind_e dest_kind;
    logic use_short;
    logic no_label_ok;
    logic [7:0] fragment_tag;
    logic [11:0] payload_len;
    logic [15:0] total_len;
    logic [15:0] proto;
    logic [47:0] attach_point_address;
  } pdu_req_s;

  // Ethernet-style mapping of an IPv4 group address
  function automatic logic [47:0] map_mcast_v4(input logic [31:0] grp);
    map_mcast_v4 = {MCAST4_PREFIX, 1'b0, grp[22:0]};
  endfunction : map_mcast_v4

  // Ethernet-style mapping of the low word of an IPv6 group address
  function automatic logic [47:0] map_mcast_v6(input logic [31:0] grp);
    map_mcast_v6 = {MCAST6_PREFIX, grp};
  endfunction : map_mcast_v6

  // Byte count of a label for a given kind code
  function automatic logic [11:0] label_bytes(input logic [1:0] kind);
    case (kind)
      LABEL_KIND_SIX: label_bytes = LABEL_SIX_BYTES;
      LABEL_KIND_THREE: label_bytes = LABEL_THREE_BYTES;
      default: label_bytes = 12'h000;
    endcase
  endfunction : label_bytes

endpackage : gse_encap_pkg

// >>> core/label_former.sv
// Forms the destination label for one packet order
`timescale 1ns/10ps
module label_former
  import gse_encap_pkg::*;
(
  input wire pdu_req_s req_i,
  input wire logic group_map_i,
  input wire logic [2:0] short_binding_i,
  output logic [47:0] label_o,
  output logic label_bad_o
);

  logic binding_ok;

  // Short labels need a legal, non-empty binding
  always_comb begin
    case (short_binding_i) // [RULE21]
      BIND_GROUP_LOGON, BIND_ATM_PVC, BIND_VLAN: binding_ok = 1'b1;
      default: binding_ok = 1'b0;
    endcase
  end

  // Label value by destination kind
  always_comb begin
    label_o = req_i.attach_point_address; // [RULE19]
    case (req_i.dest_kind)
      DEST_BROADCAST: label_o = LABEL_BROADCAST; // [RULE6] [RULE7]
      DEST_MCAST_V4: begin
        // Without the group-map flag the caller supplies the mapped label
        if (group_map_i) begin // [RULE20]
          label_o = map_mcast_v4(req_i.attach_point_address[31:0]); // [RULE8] [RULE5]
        end
      end
      DEST_MCAST_V6: begin
        if (group_map_i) begin // [RULE20]
          label_o = map_mcast_v6(req_i.attach_point_address[31:0]); // [RULE8] [RULE5]
        end
      end
      default: label_o = req_i.attach_point_address;
    endcase
    if (req_i.use_short) begin
      label_o = {24'h000000, req_i.attach_point_address[23:0]};
    end
  end

  // Zero label or unusable short label refuses the order
  assign label_bad_o = (req_i.use_short ? (label_o[23:0] == 24'h000000) || !binding_ok
                                        : (label_o == LABEL_ZERO)); // [RULE4] [RULE21]

endmodule : label_former

// >>> core/gse_label_filter.sv
// Packet header encapsulator that feeds labelled packets to a label-filtering receiver
//
// Functional notes
// RULE1: Kind 00 puts six-byte label after protocol
// RULE2: Kind 01 puts three-byte label after protocol
// RULE3: Labels for routed unicast; none only when allowed
// RULE4: Never send an all-zero label
// RULE5: Low bit of first byte marks multicast
// RULE6: All-ones label means deliver to everyone
// RULE7: Subnet broadcast uses the all-ones label
// RULE8: Multicast label mapped from IP group address
// RULE9: First packet labelled, later ones may reuse
// RULE10: Reuse only inside one baseband frame
// RULE11: Receiver walks packets by their length fields; label_rx_model ignores them and walks by last_i instead
// RULE12: Receiver filters labels of start packets
// RULE13: Receiver accepts no-label packets unfiltered
// RULE14: Receiver accepts reuse only after accepted packet
// RULE15: Never reuse right after a no-label packet
// RULE16: Receiver passes whole packets straight to delivery
// RULE17: Receiver keeps reassembly per stream and PDU
// RULE18: Receiver has reassembly buffer per bound address
// RULE19: Unicast terminals filter on hardware MAC address
// RULE20: Group-map flag selects standard multicast mapping
// RULE21: Short-label binding code decode, reserved bits follow
// RULE22: Receiver treats padding header as frame end
// RULE23: Receiver drops leading reuse packets of a frame
// RULE24: Receiver sends non-start packets to reassembly
// RULE25: Receiver forgets accept decision at new frame
`timescale 1ns/10ps
module gse_label_filter
  import gse_encap_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic group_map_i,
  input wire logic [2:0] short_binding_i,
  input wire logic req_valid_i,
  input wire pdu_req_s req_i,
  output logic req_ready_o,
  output logic req_reject_o,
  input wire logic pay_valid_i,
  input wire logic [7:0] pay_data_i,
  output logic pay_ready_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic out_last_o,
  input wire logic out_ready_i
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DECIDE,
    ST_HDR,
    ST_PAY
  } enc_state_e;

  enc_state_e state_q;
  pdu_req_s req_q;
  logic [47:0] label_w;
  logic label_bad_w;
  logic [7:0] hdr_q [HDR_MAX_BYTES];
  logic [7:0] hdr_d [HDR_MAX_BYTES];
  logic [3:0] hdr_n_q;
  logic [3:0] hdr_n_d;
  logic [3:0] hdr_idx_q;
  logic [11:0] pay_cnt_q;
  logic [1:0] kind_d;
  logic reuse_ok;
  logic bad_order;
  logic last_valid_q;
  logic last_none_q;
  logic last_short_q;
  logic [47:0] last_label_q;

  label_former u_label_former (
    .req_i(req_q),
    .group_map_i(group_map_i),
    .short_binding_i(short_binding_i),
    .label_o(label_w),
    .label_bad_o(label_bad_w)
  );

  // Reuse only when the previous packet in this frame bore the same label
  assign reuse_ok = last_valid_q && !last_none_q && (last_short_q == req_q.use_short) &&
                    (last_label_q == label_w); // [RULE9] [RULE15]

  // Label needed but unusable; the no-label route avoids the check
  assign bad_order = req_q.first_frag && label_bad_w && !reuse_ok && !req_q.no_label_ok;

  // Choose the label kind code
  always_comb begin
    if (!req_q.first_frag) begin
      kind_d = LABEL_KIND_REUSE; // Intermediate and end packets carry no label
    end else if (reuse_ok) begin
      kind_d = LABEL_KIND_REUSE; // [RULE9]
    end else if (req_q.no_label_ok) begin
      kind_d = LABEL_KIND_NONE; // [RULE3]
    end else if (req_q.use_short) begin
      kind_d = LABEL_KIND_THREE; // [RULE2]
    end else begin
      kind_d = LABEL_KIND_SIX; // [RULE1] [RULE3]
    end
  end

  // Build header bytes in wire order
  always_comb begin
    logic [11:0] extra;
    logic [11:0] gse_len;
    logic [15:0] tot;
    logic [3:0] p;
    extra = 12'h000;
    gse_len = 12'h000;
    tot = 16'h0000;
    p = 4'h0;
    for (int i = 0; i < HDR_MAX_BYTES; i++) begin
      hdr_d[i] = 8'h00;
    end
    if (!(req_q.first_frag && req_q.last_frag)) begin
      extra = extra + FRAG_TAG_BYTES;
    end
    if (req_q.first_frag && !req_q.last_frag) begin
      extra = extra + TOTAL_LEN_BYTES;
    end
    if (req_q.first_frag) begin
      extra = extra + PROTO_BYTES + label_bytes(kind_d);
    end
    gse_len = extra + req_q.payload_len;
    tot = req_q.total_len + {4'h0, PROTO_BYTES} + {4'h0, label_bytes(kind_d)};
    hdr_d[0] = {req_q.first_frag, req_q.last_frag, kind_d, gse_len[11:8]};
    hdr_d[1] = gse_len[7:0];
    p = 4'h2;
    if (!(req_q.first_frag && req_q.last_frag)) begin
      hdr_d[p] = req_q.fragment_tag;
      p = p + 4'h1;
    end
    if (req_q.first_frag && !req_q.last_frag) begin
      hdr_d[p] = tot[15:8];
      hdr_d[p + 4'h1] = tot[7:0];
      p = p + 4'h2;
    end
    if (req_q.first_frag) begin
      hdr_d[p] = req_q.proto[15:8];
      hdr_d[p + 4'h1] = req_q.proto[7:0];
      p = p + 4'h2;
      // Label follows the protocol field directly
      if (kind_d == LABEL_KIND_SIX) begin // [RULE1]
        for (int b = 0; b < 6; b++) begin
          hdr_d[p] = label_w[47 - 8 * b -: 8];
          p = p + 4'h1;
        end
      end else if (kind_d == LABEL_KIND_THREE) begin // [RULE2]
        for (int b = 0; b < 3; b++) begin
          hdr_d[p] = label_w[23 - 8 * b -: 8];
          p = p + 4'h1;
        end
      end
    end
    hdr_n_d = p;
  end

  // Packet sequencing
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_valid_i) begin
            state_q <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          state_q <= bad_order ? ST_IDLE : ST_HDR; // [RULE4]
        end
        ST_HDR: begin
          if (out_ready_i && (hdr_idx_q == hdr_n_q - 4'h1)) begin
            state_q <= (req_q.payload_len == 12'h000) ? ST_IDLE : ST_PAY;
          end
        end
        ST_PAY: begin
          if (pay_valid_i && out_ready_i && (pay_cnt_q == req_q.payload_len - 12'h001)) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Order capture
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_q <= '0;
    end else if (state_q == ST_IDLE && req_valid_i) begin
      req_q <= req_i;
    end
  end

  // Header store and byte indices
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hdr_n_q <= 4'h0;
      hdr_idx_q <= 4'h0;
      pay_cnt_q <= 12'h000;
      for (int i = 0; i < HDR_MAX_BYTES; i++) begin
        hdr_q[i] <= 8'h00;
      end
    end else if (state_q == ST_DECIDE) begin
      hdr_q <= hdr_d;
      hdr_n_q <= hdr_n_d;
      hdr_idx_q <= 4'h0;
      pay_cnt_q <= 12'h000;
    end else if (state_q == ST_HDR && out_ready_i) begin
      hdr_idx_q <= hdr_idx_q + 4'h1;
    end else if (state_q == ST_PAY && out_ready_i && pay_valid_i) begin
      pay_cnt_q <= pay_cnt_q + 12'h001;
    end
  end

  // Reuse memory; a new frame wipes it, which wins over a same-cycle update
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      last_valid_q <= 1'b0;
      last_none_q <= 1'b0;
      last_short_q <= 1'b0;
      last_label_q <= LABEL_ZERO;
    end else if (frame_start_i) begin
      last_valid_q <= 1'b0; // [RULE10]
      last_none_q <= 1'b0;
    end else if (state_q == ST_DECIDE && !bad_order) begin
      // Any non-start packet breaks the chain the receiver relies on
      last_valid_q <= req_q.first_frag && (kind_d != LABEL_KIND_NONE);
      last_none_q <= req_q.first_frag && (kind_d == LABEL_KIND_NONE); // [RULE15]
      last_short_q <= req_q.use_short;
      last_label_q <= label_w;
    end
  end

  // Refusal pulse
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_reject_o <= 1'b0;
    end else begin
      req_reject_o <= (state_q == ST_DECIDE) && bad_order;
    end
  end

  // Output stream; payload bytes pass through without buffering
  assign req_ready_o = (state_q == ST_IDLE);
  assign pay_ready_o = (state_q == ST_PAY) && out_ready_i;
  assign out_valid_o = (state_q == ST_HDR) || ((state_q == ST_PAY) && pay_valid_i);
  assign out_data_o = (state_q == ST_PAY) ? pay_data_i : hdr_q[hdr_idx_q];
  assign out_last_o = ((state_q == ST_HDR) && (hdr_idx_q == hdr_n_q - 4'h1) && (req_q.payload_len == 12'h000)) ||
                      ((state_q == ST_PAY) && (pay_cnt_q == req_q.payload_len - 12'h001));

endmodule : gse_label_filter

// >>> verification/gse_label_filter_props.sv
// Port checker for the packet header encapsulator
`timescale 1ns/10ps
module gse_label_filter_props
  import gse_encap_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] short_binding_i,
  input wire logic req_valid_i,
  input wire pdu_req_s req_i,
  input wire logic req_ready_o,
  input wire logic req_reject_o,
  input wire logic pay_ready_o,
  input wire logic out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic out_last_o,
  input wire logic out_ready_i
);
  wire logic take = req_valid_i && req_ready_o;
  wire logic lab = take && req_i.first_frag && !req_i.no_label_ok && req_i.dest_kind == DEST_UNICAST;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_reject_single: assert property (req_reject_o |=> !req_reject_o)
    else $error("reject pulse too long");
  a_take_answer: assert property (take |=> !req_ready_o ##1 (req_reject_o || out_valid_o))
    else $error("no answer two cycles after order");
  a_hold_byte: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("byte changed while stalled");
  a_busy_excl: assert property (out_valid_o |-> !req_ready_o && !req_reject_o)
    else $error("ready or reject during packet");
  a_pay_gate: assert property (pay_ready_o |-> out_ready_i)
    else $error("payload taken while stalled");
  a_last_idle: assert property (out_valid_o && out_last_o && out_ready_i |=> req_ready_o && !out_valid_o)
    else $error("not idle after last byte");
  a_zero_drop: assert property (
    lab && !req_i.use_short && req_i.attach_point_address == LABEL_ZERO |=> ##1 req_reject_o)
    else $error("zero label not refused");
  a_bad_bind: assert property (
    lab && req_i.use_short && !(short_binding_i inside {3'h4, 3'h2, 3'h1}) |=> ##1 req_reject_o)
    else $error("short label with bad binding not refused");
  a_frag_kind: assert property (
    take && !req_i.first_frag |=> ##1 out_valid_o && out_data_o[5:4] == 2'h3 && !out_data_o[7])
    else $error("fragment header kind wrong");
endmodule : gse_label_filter_props

bind gse_label_filter gse_label_filter_props chk_u (.core_clk_i, .rst_i, .short_binding_i, .req_valid_i, .req_i,
  .req_ready_o, .req_reject_o, .pay_ready_o, .out_valid_o, .out_data_o, .out_last_o, .out_ready_i);

// >>> verification/label_rx_model.sv
// Receiving end model: walks packets, filters labels, counts outcomes
`timescale 1ns/10ps
module label_rx_model
  import gse_encap_pkg::*;
#(
  parameter logic [47:0] MY_ADDR = 48'h0200_0000_0a01
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  output logic ready_o,
  output logic [1:0] kind_o,
  output logic [47:0] label_o,
  output logic [7:0] whole_o,
  output logic [7:0] frag_o,
  output logic [7:0] drop_o
);
  logic [11:0] idx_q, ls, ln;
  logic s_q, e_q, tog_q, prev_ok_q, first_q, ok, tk;
  logic [47:0] lab;
  logic skip_q, open_q, hit;
  logic [7:0] tag_in_q, tag_q, cur_tag;
  // Fragment tag sits at byte 2 of every packet that is not whole
  assign cur_tag = (idx_q == 12'h2) ? data_i : tag_in_q;
  assign hit = open_q && (cur_tag == tag_q);
  // Padding ends the useful part of a frame; one reassembly slot for the one bound address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_q <= 1'b0;
      open_q <= 1'b0;
    end else begin
      if (frame_start_i) begin
        skip_q <= 1'b0;
      end else if (tk && idx_q == 12'h0 && data_i[7:4] == 4'h0) begin
        skip_q <= 1'b1;
      end
      if (tk && idx_q == 12'h2) begin
        tag_in_q <= data_i;
      end
      if (tk && last_i && !skip_q && s_q && !e_q && ok) begin
        tag_q <= cur_tag;
        open_q <= 1'b1;
      end else if (tk && last_i && !skip_q && !s_q && e_q && hit) begin
        open_q <= 1'b0;
      end
    end
  end
  // Slow mode refuses on every other cycle
  assign ready_o = !(stall_i && tog_q);
  assign tk = valid_i && ready_o;
  // Label follows protocol field
  assign ls = 12'h4 + {11'h0, !(s_q && e_q)} + ((s_q && !e_q) ? 12'h2 : 12'h0);
  assign ln = (kind_o == 2'h0) ? 12'h6 : ((kind_o == 2'h1) ? 12'h3 : 12'h0);
  assign lab = (s_q && idx_q >= ls && idx_q < ls + ln) ? {label_o[39:0], data_i} : label_o;
  // Filter decision
  always_comb begin
    case (kind_o)
      2'h2: ok = 1'b1;
      2'h3: ok = prev_ok_q && !first_q;
      2'h1: ok = lab[23:0] == MY_ADDR[23:0];
      default: ok = lab == MY_ADDR || lab == 48'hffff_ffff_ffff || lab[40];
    endcase
  end
  // Re-use memory lasts one frame only
  always_ff @(posedge clk_i) begin
    if (rst_i || frame_start_i) begin
      prev_ok_q <= 1'b0;
      first_q <= 1'b1;
    end else if (tk && last_i && !skip_q) begin
      prev_ok_q <= s_q ? ok : prev_ok_q;
      first_q <= 1'b0;
    end
  end
  // Header walk and outcome counts
  always_ff @(posedge clk_i) begin
    tog_q <= !rst_i && !tog_q;
    if (rst_i) begin
      idx_q <= 12'h0;
      whole_o <= 8'h0;
      frag_o <= 8'h0;
      drop_o <= 8'h0;
    end else if (tk) begin
      idx_q <= last_i ? 12'h0 : idx_q + 12'h1;
      label_o <= (idx_q == 12'h0) ? 48'h0 : lab;
      if (idx_q == 12'h0) begin
        s_q <= data_i[7];
        e_q <= data_i[6];
        kind_o <= data_i[5:4];
      end
      if (last_i && !skip_q && ((!s_q && hit) || (s_q && ok && !e_q))) frag_o <= frag_o + 8'h1;
      if (last_i && (skip_q || (s_q && !ok) || (!s_q && !hit))) drop_o <= drop_o + 8'h1;
      if (last_i && !skip_q && s_q && ok && e_q) whole_o <= whole_o + 8'h1;
    end
  end
endmodule : label_rx_model

// >>> verification/gse_label_filter_tb.sv
// Testbench for the packet header encapsulator
`timescale 1ns/10ps
module gse_label_filter_tb
  import gse_encap_pkg::*;
;
  localparam logic [47:0] ME = 48'h0200_0000_0a01;
  logic core_clk_i, rst_i, frame_start_i, group_map_i, req_valid_i, pay_valid_i, stall, rej, pay_take;
  logic req_ready_o, req_reject_o, pay_ready_o, out_valid_o, out_last_o, out_ready_i;
  logic [2:0] short_binding_i;
  logic [7:0] pay_data_i, out_data_o, whole, frag, drop;
  logic [1:0] kind;
  logic [47:0] label;
  pdu_req_s req_i;
  int miscompares, check_count, cycles;
  gse_label_filter dut_u (.core_clk_i, .rst_i, .frame_start_i, .group_map_i, .short_binding_i, .req_valid_i,
    .req_i, .req_ready_o, .req_reject_o, .pay_valid_i, .pay_data_i, .pay_ready_o, .out_valid_o, .out_data_o,
    .out_last_o, .out_ready_i);
  label_rx_model #(.MY_ADDR(ME)) rx_u (.clk_i(core_clk_i), .rst_i, .frame_start_i, .stall_i(stall),
    .valid_i(out_valid_o), .data_i(out_data_o), .last_i(out_last_o), .ready_o(out_ready_i), .kind_o(kind),
    .label_o(label), .whole_o(whole), .frag_o(frag), .drop_o(drop));
  always #2 core_clk_i = ~core_clk_i;
  // Fresh payload byte after each take, changed on the falling edge like every other input but out_ready_i
  always @(posedge core_clk_i) pay_take <= pay_valid_i && pay_ready_o;
  always @(negedge core_clk_i) begin
    if (rst_i) begin
      pay_data_i <= 8'h00;
    end else if (pay_take) begin
      pay_data_i <= pay_data_i + 8'h1;
    end
  end
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // Hang guard, far above the expected run length
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  function automatic pdu_req_s mk(input logic [1:0] se, input dest_kind_e dk, input logic sh, input logic nl,
                                  input logic [47:0] a);
    mk = '{se[1], se[0], dk, sh, nl, 8'h05, 12'h002, 16'h0040, 16'h0800, a};
  endfunction : mk
  // One order; waits bounded until idle, noting any refusal
  task automatic send(input pdu_req_s r);
    int n;
    rej = 1'b0;
    n = 0;
    @(negedge core_clk_i);
    req_i = r;
    req_valid_i = 1'b1;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    do begin
      @(negedge core_clk_i);
      rej = rej | req_reject_o;
      n++;
    end while (!req_ready_o && n < 300);
    if (!req_ready_o) begin
      $display("ERROR t=%0t ready=%h exp=%h", $time, req_ready_o, 1'b1);
      miscompares++;
    end
  endtask : send
  task automatic run(input pdu_req_s r, input logic [1:0] ek, input logic [47:0] el);
    send(r);
    chk({47'h0, rej}, 48'h0);
    chk({46'h0, kind}, {46'h0, ek});
    if (ek[1] == 1'b0) chk(label, el);
  endtask : run
  task automatic new_frame();
    @(negedge core_clk_i);
    frame_start_i = 1'b1;
    @(negedge core_clk_i);
    frame_start_i = 1'b0;
  endtask : new_frame
  initial begin
    pdu_req_s r;
    {core_clk_i, rst_i, frame_start_i, group_map_i, req_valid_i, pay_valid_i, stall} = 7'h20;
    {short_binding_i, req_i} = '0;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    pay_valid_i = 1'b1;
    chk({46'h0, req_ready_o, out_valid_o}, 48'h2);
    r = mk(2'b11, DEST_UNICAST, 1'b0, 1'b0, ME);
    run(r, 2'h0, ME);
    run(r, 2'h3, ME);
    new_frame();
    run(r, 2'h0, ME);
    stall = 1'b1;
    run(mk(2'b11, DEST_BROADCAST, 1'b0, 1'b0, 48'h1234), 2'h0, 48'hffff_ffff_ffff);
    stall = 1'b0;
    group_map_i = 1'b1;
    run(mk(2'b11, DEST_MCAST_V4, 1'b0, 1'b0, 48'he0ff_8102), 2'h0, 48'h0100_5e7f_8102);
    run(mk(2'b11, DEST_MCAST_V6, 1'b0, 1'b0, 48'h0000_ff00_0001), 2'h0, 48'h3333_ff00_0001);
    group_map_i = 1'b0;
    run(mk(2'b11, DEST_MCAST_V4, 1'b0, 1'b0, 48'h0300_0000_0009), 2'h0, 48'h0300_0000_0009);
    for (int b = 0; b < 8; b++) begin
      short_binding_i = 3'(b);
      r = mk(2'b11, DEST_UNICAST, 1'b1, 1'b0, 48'h10 + 48'(b));
      if (b == 4 || b == 2 || b == 1) run(r, 2'h1, 48'h10 + 48'(b));
      else send(r);
      if (!(b == 4 || b == 2 || b == 1)) chk({47'h0, rej}, 48'h1);
    end
    send(mk(2'b11, DEST_UNICAST, 1'b0, 1'b0, 48'h0));
    chk({47'h0, rej}, 48'h1);
    run(mk(2'b11, DEST_UNICAST, 1'b0, 1'b1, ME), 2'h2, ME);
    run(mk(2'b11, DEST_UNICAST, 1'b0, 1'b0, ME), 2'h0, ME);
    new_frame();
    run(mk(2'b10, DEST_UNICAST, 1'b0, 1'b0, ME), 2'h0, ME);
    run(mk(2'b01, DEST_UNICAST, 1'b0, 1'b0, ME), 2'h3, ME);
    chk({24'h0, whole, frag, drop}, 48'h09_02_03);
    give_verdict();
  end
endmodule : gse_label_filter_tb
